// ### dv/testbench.sv
// self-checking bench for the baud generator and path control
// assumes the design package; inputs change on the falling edge
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import ubg_pkg::*;
    logic             ref_clk = 1'b0, rst = 1'b1;
    logic             bw, mw, ew, clock_output_enable, over, run, rxe, rxd, rxs, txe, txd, txs, rxb, txb, txh, txg;
    logic [CD_W-1:0]  cd, cd_q;
    logic [FP_W-1:0]  fp, fp_q;
    logic [1:0]       src, mode;
    logic [ETU_W-1:0] etu, etu_q;
    logic             sck, sck_out, sck_oe, smp, baud, rxa, txa, rxf, txf;
    int               bad_count = 0, check_count = 0, n;

    always #5 ref_clk = ~ref_clk;

    ubg_sck_partner u_partner (.run(run), .sck(sck));
    ubg_top u_dut (
        .ref_clk(ref_clk), .rst(rst), .baud_divider_register_we(bw), .clock_divisor_in(cd),
        .fractional_part_in(fp), .mode_register_we(mw), .clock_source_select_in(src), .op_mode_in(mode),
        .over_in(over), .clock_output_enable_in(clock_output_enable), .etu_ratio_register_we(ew), .etu_sample_count_in(etu),
        .receive_enable_cmd(rxe), .receive_disable_cmd(rxd), .receive_soft_reset(rxs),
        .transmit_enable_cmd(txe), .transmit_disable_cmd(txd), .transmit_soft_reset(txs),
        .rx_char_busy(rxb), .tx_char_busy(txb), .tx_holding_full(txh), .tx_timeguard_busy(txg),
        .sck_in(sck), .sck_out(sck_out), .sck_oe(sck_oe), .sample_tick(smp), .baud_tick(baud),
        .rx_active(rxa), .tx_active(txa), .rx_flush(rxf), .tx_flush(txf), .clock_divisor_q(cd_q),
        .fractional_part_q(fp_q), .etu_sample_count_q(etu_q)
    );

    task automatic print_verdict;
        if (bad_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge ref_clk);
    endtask

    task automatic do_reset;
        rst = 1'b1;
        cyc(5);
        rst = 1'b0;
    endtask

    // bits: rx en, dis, rst, tx en, dis, rst
    task automatic cmd(input logic [5:0] c);
        {rxe, rxd, rxs, txe, txd, txs} = c;
        cyc(1);
        {rxe, rxd, rxs, txe, txd, txs} = 6'h00;
    endtask

    task automatic cfg(input logic [1:0] s, m, input logic o, k, input logic [CD_W-1:0] c,
                       input logic [FP_W-1:0] f, input logic [ETU_W-1:0] e);
        {src, mode, over, clock_output_enable, cd, fp, etu} = {s, m, o, k, c, f, e};
        {bw, mw, ew} = 3'h7;
        cyc(1);
        {bw, mw, ew} = 3'h0;
        cyc(2);
    endtask

    // cycles between the second and third event seen
    task automatic period(input string what, input bit use_sck, input int exp);
        int   k = 0, t = 0;
        logic prev = 1'b0, ev;
        while (t < 3 && k < 3000) begin
            cyc(1);
            k++;
            ev = use_sck ? (sck_out && !prev) : baud;
            prev = sck_out;
            if (ev === 1'b1) begin
                if (t == 2) check(what, k, exp);
                t++;
                k = 0;
            end
        end
        if (t < 3) check(what, 0, exp);
    endtask

    function automatic int exp_baud(input logic [1:0] s, m, input logic o, input int c, f, e);
        int r;
        r = (m == UBG_MODE_ASYNC) ? (2 - o) * (8 * c + f) : (m == UBG_MODE_CARD) ? c * e : c;
        return (s == UBG_SRC_DIV) ? r * (MCK_DIV_LAST + 1) : r;
    endfunction

    task automatic run_case(input logic [1:0] s, m, input logic o, input logic [CD_W-1:0] c,
                            input logic [FP_W-1:0] f, input logic [ETU_W-1:0] e);
        cfg(s, m, o, 1'b0, c, f, e);
        check("divisor readback", cd_q, c);
        check("fraction readback", fp_q, f);
        period("baud_tick period", 1'b0, exp_baud(s, m, o, c, f, e));
    endtask

    initial begin
        #200000;
        bad_count++;
        print_verdict();
    end

    initial begin
        {bw, mw, ew, clock_output_enable, over, run, rxe, rxd, rxs, txe, txd, txs, rxb, txb, txh, txg} = '0;
        {cd, fp, src, mode, etu} = '0;
        void'($urandom(32'h566b));
        do_reset();
        cyc(4);
        check("rx_active", rxa, 1'b0);
        check("tx_active", txa, 1'b0);
        check("etu readback", etu_q, ETU_RESET);
        cfg(UBG_SRC_MCK, UBG_MODE_CARD, 1'b0, 1'b0, 16'hffff, 3'h7, 11'h7ff);
        check("divisor readback", cd_q, 16'hffff);
        check("etu readback", etu_q, 11'h7ff);
        cfg(UBG_SRC_MCK, UBG_MODE_ASYNC, 1'b1, 1'b0, CD_OFF, FP_NONE, ETU_RESET);
        n = 0;
        repeat (40) begin
            cyc(1);
            if (smp !== 1'b0) n++;
        end
        check("ticks with divisor zero", n, 0);
        run_case(UBG_SRC_MCK, UBG_MODE_ASYNC, 1'b1, 16'h0002, 3'h0, ETU_RESET);
        run_case(UBG_SRC_MCK, UBG_MODE_ASYNC, 1'b0, 16'h0003, 3'h0, ETU_RESET);
        run_case(UBG_SRC_MCK, UBG_MODE_ASYNC, 1'b1, 16'h0002, 3'h4, ETU_RESET);
        run_case(UBG_SRC_MCK, UBG_MODE_ASYNC, 1'b0, 16'h0001, 3'h0, ETU_RESET);
        run_case(UBG_SRC_MCK, UBG_MODE_SYNC, 1'b0, 16'h0005, 3'h4, ETU_RESET);
        run_case(UBG_SRC_MCK, UBG_MODE_SPI, 1'b1, 16'h0004, 3'h0, ETU_RESET);
        run_case(UBG_SRC_MCK, UBG_MODE_CARD, 1'b0, 16'h0002, 3'h0, 11'h003);
        run_case(UBG_SRC_DIV, UBG_MODE_SYNC, 1'b0, 16'h0002, 3'h0, ETU_RESET);
        for (int i = 0; i < 6; i++) begin
            run_case(UBG_SRC_MCK, 2'($urandom_range(3)), 1'($urandom_range(1)), 16'($urandom_range(8, 1)),
                     3'($urandom_range(7)), 11'($urandom_range(8, 1)));
        end
        run = 1'b1;
        cfg(UBG_SRC_EXT, UBG_MODE_SYNC, 1'b0, 1'b1, 16'h0003, 3'h0, ETU_RESET);
        period("external baud_tick period", 1'b0, 8);
        check("sck_oe external", sck_oe, 1'b0);
        run = 1'b0;
        cfg(UBG_SRC_MCK, UBG_MODE_SYNC, 1'b0, 1'b1, 16'h0006, 3'h0, ETU_RESET);
        check("sck_oe master", sck_oe, 1'b1);
        period("sck_out period", 1'b1, 6);
        cmd(6'b110000);
        cyc(3);
        check("rx_active enable with disable", rxa, 1'b0);
        cmd(6'b100100);
        cyc(2);
        check("rx_active", rxa, 1'b1);
        check("tx_active", txa, 1'b1);
        rxb = 1'b1;
        cmd(6'b001000);
        check("rx_flush", rxf, 1'b1);
        cyc(1);
        check("rx_active after soft reset", rxa, 1'b0);
        check("tx_active after rx soft reset", txa, 1'b1);
        check("divisor after soft reset", cd_q, 16'h0006);
        cmd(6'b100000);
        cyc(2);
        check("rx_active alone", rxa, 1'b1);
        cmd(6'b010000);
        cyc(6);
        check("rx_active in character", rxa, 1'b1);
        rxb = 1'b0;
        cyc(4);
        check("rx_active after character", rxa, 1'b0);
        {txb, txh} = 2'b11;
        cmd(6'b000010);
        cyc(4);
        txb = 1'b0;
        cyc(4);
        check("tx_active holding full", txa, 1'b1);
        {txh, txg} = 2'b01;
        cyc(4);
        check("tx_active timeguard", txa, 1'b1);
        txg = 1'b0;
        cyc(4);
        check("tx_active after drain", txa, 1'b0);
        cmd(6'b000100);
        cyc(2);
        cmd(6'b000001);
        check("tx_flush", txf, 1'b1);
        check("tx_active after soft reset", txa, 1'b0);
        do_reset();
        cyc(1);
        check("divisor after reset", cd_q, CD_OFF);
        check("etu after reset", etu_q, ETU_RESET);
        print_verdict();
    end
endmodule

bind ubg_top ubg_top_props u_props (
    .ref_clk(ref_clk), .rst(rst), .baud_divider_register_we(baud_divider_register_we),
    .clock_divisor_in(clock_divisor_in), .fractional_part_in(fractional_part_in),
    .etu_ratio_register_we(etu_ratio_register_we), .etu_sample_count_in(etu_sample_count_in),
    .receive_enable_cmd(receive_enable_cmd), .receive_disable_cmd(receive_disable_cmd),
    .receive_soft_reset(receive_soft_reset), .transmit_enable_cmd(transmit_enable_cmd),
    .transmit_disable_cmd(transmit_disable_cmd), .transmit_soft_reset(transmit_soft_reset),
    .rx_char_busy(rx_char_busy), .tx_char_busy(tx_char_busy), .tx_holding_full(tx_holding_full),
    .tx_timeguard_busy(tx_timeguard_busy), .rx_active(rx_active), .tx_active(tx_active),
    .rx_flush(rx_flush), .tx_flush(tx_flush), .clock_divisor_q(clock_divisor_q),
    .etu_sample_count_q(etu_sample_count_q)
);

// ### dv/ubg_sck_partner.sv
// remote device driving the external serial clock pin
// assumes the bench starts it only for external-clock transfers
module ubg_sck_partner #(
    parameter int HALF_NS = 40
) (
    // control
    input  wire logic run,
    // serial clock pin
    output logic      sck
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle low between frames, eight times slower than ref_clk
    initial begin
        sck = 1'b0;
        #3;
        forever begin
            if (run) begin
                #(HALF_NS) sck = ~sck;
            end else begin
                sck = 1'b0;
                #10;
            end
        end
    end
endmodule

// ### dv/ubg_top_props.sv
// assertions on the ports of the baud generator top
// assumes a bind from the testbench and the single clock ref_clk
module ubg_top_props
    import ubg_pkg::*;
(
    // clock and reset
    input wire logic             ref_clk,
    input wire logic             rst,
    // writes
    input wire logic             baud_divider_register_we,
    input wire logic [CD_W-1:0]  clock_divisor_in,
    input wire logic [FP_W-1:0]  fractional_part_in,
    input wire logic             etu_ratio_register_we,
    input wire logic [ETU_W-1:0] etu_sample_count_in,
    // commands
    input wire logic             receive_enable_cmd,
    input wire logic             receive_disable_cmd,
    input wire logic             receive_soft_reset,
    input wire logic             transmit_enable_cmd,
    input wire logic             transmit_disable_cmd,
    input wire logic             transmit_soft_reset,
    // activity
    input wire logic             rx_char_busy,
    input wire logic             tx_char_busy,
    input wire logic             tx_holding_full,
    input wire logic             tx_timeguard_busy,
    // outputs watched
    input wire logic             rx_active,
    input wire logic             tx_active,
    input wire logic             rx_flush,
    input wire logic             tx_flush,
    input wire logic [CD_W-1:0]  clock_divisor_q,
    input wire logic [ETU_W-1:0] etu_sample_count_q
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    wire tx_pend = tx_char_busy || tx_holding_full || tx_timeguard_busy;

    sequence s_rx_go;
        receive_enable_cmd && !receive_disable_cmd && !receive_soft_reset && !rx_active
        ##1 !receive_disable_cmd && !receive_soft_reset;
    endsequence
    sequence s_tx_go;
        transmit_enable_cmd && !transmit_disable_cmd && !transmit_soft_reset && !tx_active
        ##1 !transmit_disable_cmd && !transmit_soft_reset;
    endsequence
    sequence s_rx_hold;
        rx_active && rx_char_busy && receive_disable_cmd && !receive_soft_reset
        ##1 rx_char_busy && !receive_soft_reset;
    endsequence
    sequence s_tx_hold;
        tx_active && tx_pend && transmit_disable_cmd && !transmit_soft_reset
        ##1 tx_pend && !transmit_soft_reset;
    endsequence

    a_rx_enable_delay: assert property (s_rx_go |-> ##1 rx_active)
        else $error("rx not active after enable");
    a_tx_enable_delay: assert property (s_tx_go |-> ##1 tx_active)
        else $error("tx not active after enable");
    a_rx_drain_hold: assert property (s_rx_hold |=> rx_active)
        else $error("rx stopped inside a character");
    a_tx_drain_hold: assert property (s_tx_hold |=> tx_active)
        else $error("tx stopped with work pending");
    a_rx_flush_pulse: assert property (receive_soft_reset |=> rx_flush)
        else $error("rx flush missing");
    a_tx_flush_cause: assert property (tx_flush |-> $past(transmit_soft_reset))
        else $error("tx flush without soft reset");
    a_rx_reset_idle: assert property (receive_soft_reset ##1 !receive_enable_cmd |=> !rx_active)
        else $error("rx active after soft reset");
    a_reset_values: assert property ($fell(rst) |-> !rx_active && !tx_active
        && etu_sample_count_q == ETU_RESET && clock_divisor_q == CD_OFF) else $error("bad value after reset");
    a_cd_readback: assert property (baud_divider_register_we |->
        ##2 clock_divisor_q == $past(clock_divisor_in, 2)) else $error("divisor readback wrong");
    a_etu_readback: assert property (etu_ratio_register_we |->
        ##2 etu_sample_count_q == $past(etu_sample_count_in, 2)) else $error("etu readback wrong");
endmodule

// ### hw/ubg_path_ctl.sv
// enable / disable / soft-reset control of one serial path (rx or tx)
// assumes command pulses and busy/pending flags on the same clock
module ubg_path_ctl
    import ubg_pkg::*;
(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // commands
    input  wire logic enable_cmd,
    input  wire logic disable_cmd,
    input  wire logic soft_reset,
    // path activity
    input  wire logic work_pending,
    // state
    output logic      active,
    output logic      path_clear
);
    ubg_path_e state_r;

    // ----------------------------------------------------------------
    // state machine
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= UBG_PATH_IDLE;
        end else if (soft_reset) begin
            state_r <= UBG_PATH_IDLE;
        end else begin
            unique case (state_r)
                UBG_PATH_IDLE: begin
                    if (enable_cmd && !disable_cmd) begin
                        state_r <= UBG_PATH_RUN;
                    end
                end
                UBG_PATH_RUN: begin
                    if (disable_cmd) begin
                        state_r <= work_pending ? UBG_PATH_DRAIN : UBG_PATH_IDLE;
                    end
                end
                UBG_PATH_DRAIN: begin
                    // enable during drain cancels the pending stop
                    if (enable_cmd) begin
                        state_r <= UBG_PATH_RUN;
                    end else if (!work_pending) begin
                        state_r <= UBG_PATH_IDLE;
                    end
                end
                default: begin
                    state_r <= UBG_PATH_IDLE;
                end
            endcase
        end
    end

    assign active     = (state_r != UBG_PATH_IDLE);
    assign path_clear = soft_reset;
endmodule

// ### hw/ubg_top.sv
// baud rate generator with rx/tx enable control of a serial port
// assumes one clock ref_clk at 100 MHz; config arrives as plain ports
module ubg_top
    import ubg_pkg::*;
(
    // clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rst,
    // configuration writes
    input  wire logic               baud_divider_register_we,
    input  wire logic [CD_W-1:0]    clock_divisor_in,
    input  wire logic [FP_W-1:0]    fractional_part_in,
    input  wire logic               mode_register_we,
    input  wire logic [1:0]         clock_source_select_in,
    input  wire logic [1:0]         op_mode_in,
    input  wire logic               over_in,
    input  wire logic               clock_output_enable_in,
    input  wire logic               etu_ratio_register_we,
    input  wire logic [ETU_W-1:0]   etu_sample_count_in,
    // control register commands, one-cycle pulses
    input  wire logic               receive_enable_cmd,
    input  wire logic               receive_disable_cmd,
    input  wire logic               receive_soft_reset,
    input  wire logic               transmit_enable_cmd,
    input  wire logic               transmit_disable_cmd,
    input  wire logic               transmit_soft_reset,
    // path activity from the shifters
    input  wire logic               rx_char_busy,
    input  wire logic               tx_char_busy,
    input  wire logic               tx_holding_full,
    input  wire logic               tx_timeguard_busy,
    // serial clock pin
    input  wire logic               sck_in,
    output logic                    sck_out,
    output logic                    sck_oe,
    // clocks and state toward the shifters
    output logic                    sample_tick,
    output logic                    baud_tick,
    output logic                    rx_active,
    output logic                    tx_active,
    output logic                    rx_flush,
    output logic                    tx_flush,
    // configuration readback
    output logic [CD_W-1:0]         clock_divisor_q,
    output logic [FP_W-1:0]         fractional_part_q,
    output logic [ETU_W-1:0]        etu_sample_count_q
);
    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    logic [CD_W-1:0]  cd_r;
    logic [FP_W-1:0]  fp_r;
    logic [ETU_W-1:0] etu_r;
    ubg_src_e         src_r;
    ubg_mode_e        mode_r;
    logic             over_r;
    logic             clock_output_enable_r;

    // writes taken regardless of rx/tx enable untouched by soft resets
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cd_r <= CD_OFF;
            fp_r <= FP_NONE;
        end else if (baud_divider_register_we) begin
            cd_r <= clock_divisor_in;
            fp_r <= fractional_part_in;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            src_r  <= UBG_SRC_MCK;
            mode_r <= UBG_MODE_ASYNC;
            over_r <= 1'b0;
            clock_output_enable_r <= 1'b0;
        end else if (mode_register_we) begin
            src_r  <= ubg_src_e'(clock_source_select_in);
            mode_r <= ubg_mode_e'(op_mode_in);
            over_r <= over_in;
            clock_output_enable_r <= clock_output_enable_in;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            etu_r <= ETU_RESET;
        end else if (etu_ratio_register_we) begin
            etu_r <= etu_sample_count_in;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            clock_divisor_q    <= CD_OFF;
            fractional_part_q  <= FP_NONE;
            etu_sample_count_q <= ETU_RESET;
        end else begin
            clock_divisor_q    <= cd_r;
            fractional_part_q  <= fp_r;
            etu_sample_count_q <= etu_r;
        end
    end

    // ----------------------------------------------------------------
    // external clock pin synchroniser
    // ----------------------------------------------------------------
    logic sck_s1_r;
    logic sck_s2_r;
    logic sck_s3_r;
    logic sck_lvl_r;

    // level changes once the second and third stages agree
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sck_s1_r  <= 1'b0;
            sck_s2_r  <= 1'b0;
            sck_s3_r  <= 1'b0;
            sck_lvl_r <= 1'b0;
        end else begin
            sck_s1_r <= sck_in;
            sck_s2_r <= sck_s1_r;
            sck_s3_r <= sck_s2_r;
            if (sck_s2_r == sck_s3_r) begin
                sck_lvl_r <= sck_s3_r;
            end
        end
    end

    logic ext_rise;
    assign ext_rise = sck_s2_r && sck_s3_r && !sck_lvl_r;

    // ----------------------------------------------------------------
    // source select
    // ----------------------------------------------------------------
    logic [2:0] pre_cnt_r;
    logic       div8_tick;
    logic       src_tick;

    always_ff @(posedge ref_clk) begin
        pre_cnt_r <= rst ? 3'h0 : pre_cnt_r + 3'h1;
    end
    assign div8_tick = (pre_cnt_r == MCK_DIV_LAST);

    always_comb begin
        unique case (src_r)
            UBG_SRC_MCK: src_tick = 1'b1;
            UBG_SRC_DIV: src_tick = div8_tick;
            UBG_SRC_EXT: src_tick = ext_rise;
            default:     src_tick = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // fractional divider, counts in eighths of a source period
    // ----------------------------------------------------------------
    logic             frac_on;
    logic             ext_direct;
    logic [CD_W+2:0]  acc_r;
    logic [CD_W+2:0]  period8;
    logic             div_tick;

    // fraction only when nonzero and in async mode
    assign frac_on    = (fp_r != FP_NONE) && (mode_r == UBG_MODE_ASYNC);
    // external pin used directly in sync and spi modes
    assign ext_direct = (mode_r inside {UBG_MODE_SYNC, UBG_MODE_SPI}) && (src_r == UBG_SRC_EXT);
    // period in eighths: 8*cd + fp
    assign period8    = {cd_r, 3'h0} + (frac_on ? {{CD_W{1'b0}}, fp_r} : {(CD_W+3){1'b0}});

    // counts down by 8 per source tick; wraps keep the fractional residue
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            acc_r <= '0;
        end else if (cd_r == CD_OFF || ext_direct) begin
            acc_r <= '0;
        end else if (src_tick) begin
            if (acc_r <= (CD_W+3)'(8)) begin
                acc_r <= acc_r + period8 - (CD_W+3)'(8);
            end else begin
                acc_r <= acc_r - (CD_W+3)'(8);
            end
        end
    end

    // zero stops, one bypasses when no fraction is on
    always_comb begin
        if (cd_r == CD_OFF) begin
            div_tick = 1'b0;
        end else if (ext_direct) begin
            div_tick = ext_rise;
        end else if (cd_r == CD_BYPASS && !frac_on) begin
            div_tick = src_tick;
        end else begin
            div_tick = src_tick && (acc_r <= (CD_W+3)'(8));
        end
    end

    // ----------------------------------------------------------------
    // oversampling and etu dividers
    // ----------------------------------------------------------------
    logic [SMP_W-1:0] smp_cnt_r;
    logic [SMP_W-1:0] smp_last;
    logic [ETU_W-1:0] etu_cnt_r;
    logic             baud_nxt;

    // x8 when over set, else x16
    assign smp_last = over_r ? OVER8_LAST : OVER16_LAST;

    always_ff @(posedge ref_clk) begin
        if (rst || mode_r != UBG_MODE_ASYNC) begin
            smp_cnt_r <= SMP_ZERO;
        end else if (div_tick) begin
            smp_cnt_r <= (smp_cnt_r >= smp_last) ? SMP_ZERO : smp_cnt_r + SMP_W'(1);
        end
    end

    // card bit time: card clock divided by the etu ratio
    always_ff @(posedge ref_clk) begin
        if (rst || mode_r != UBG_MODE_CARD) begin
            etu_cnt_r <= '0;
        end else if (div_tick) begin
            etu_cnt_r <= (etu_cnt_r + ETU_W'(1) >= etu_r) ? '0 : etu_cnt_r + ETU_W'(1);
        end
    end

    // sync/spi: bit clock is the divided clock alone
    always_comb begin
        unique case (mode_r)
            UBG_MODE_ASYNC: baud_nxt = div_tick && (smp_cnt_r >= smp_last);
            UBG_MODE_CARD:  baud_nxt = div_tick && (etu_cnt_r + ETU_W'(1) >= etu_r) && (etu_r != '0);
            default:        baud_nxt = div_tick;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sample_tick <= 1'b0;
            baud_tick   <= 1'b0;
        end else begin
            sample_tick <= div_tick;
            baud_tick   <= baud_nxt;
        end
    end

    // ----------------------------------------------------------------
    // serial clock output, 50:50 square wave for even cd and no fraction
    // ----------------------------------------------------------------
    logic [CD_W-1:0] half_cnt_r;
    logic [CD_W-1:0] half_len;
    logic [2:0]      hold_r;
    logic [2:0]      hold_min;
    logic            sck_r;
    logic            master;

    assign master   = clock_output_enable_r && !ext_direct && (cd_r != CD_OFF);
    // master rx limits clock: mck/4 serial, mck/6 spi
    assign hold_min = (mode_r == UBG_MODE_SPI) ? SPI_HALF_MIN : SYNC_HALF_MIN;
    // odd cd: low half (cd+1)/2, high half cd/2
    assign half_len = sck_r ? (cd_r >> 1) : (cd_r >> 1) + CD_W'(cd_r[0]);

    always_ff @(posedge ref_clk) begin
        if (rst || !master) begin
            sck_r      <= 1'b0;
            half_cnt_r <= '0;
            hold_r     <= 3'h0;
        end else if (src_r == UBG_SRC_MCK && mode_r != UBG_MODE_ASYNC) begin
            // mck source: half periods counted in mck cycles
            if (hold_r != 3'h7) begin
                hold_r <= hold_r + 3'h1;
            end
            if (half_cnt_r + CD_W'(1) >= half_len && hold_r >= hold_min) begin
                sck_r      <= ~sck_r;
                half_cnt_r <= '0;
                hold_r     <= 3'h0;
            end else begin
                half_cnt_r <= half_cnt_r + CD_W'(1);
            end
        end else if (sample_tick) begin
            // divided or external source, or async mode: toggle per tick, each half one sample_tick period
            sck_r <= ~sck_r;
        end
    end

    always_ff @(posedge ref_clk) begin
        sck_out <= !rst && sck_r;
        sck_oe  <= !rst && master;
    end

    // ----------------------------------------------------------------
    // receiver and transmitter control
    // ----------------------------------------------------------------
    logic rx_act;
    logic tx_act;
    logic rx_clr;
    logic tx_clr;
    logic tx_pending;

    // tx drains shifter, holding register and timeguard
    assign tx_pending = tx_char_busy || tx_holding_full || tx_timeguard_busy;

    // independent paths, enable together or alone
    // rx drains the current character disabled from reset
    ubg_path_ctl u_rx_ctl (
        .ref_clk      (ref_clk),
        .rst          (rst),
        .enable_cmd   (receive_enable_cmd),
        .disable_cmd  (receive_disable_cmd),
        .soft_reset   (receive_soft_reset),
        .work_pending (rx_char_busy),
        .active       (rx_act),
        .path_clear   (rx_clr)
    );

    // disabled from reset
    ubg_path_ctl u_tx_ctl (
        .ref_clk      (ref_clk),
        .rst          (rst),
        .enable_cmd   (transmit_enable_cmd),
        .disable_cmd  (transmit_disable_cmd),
        .soft_reset   (transmit_soft_reset),
        .work_pending (tx_pending),
        .active       (tx_act),
        .path_clear   (tx_clr)
    );

    // soft reset aborts at once and flushes flags
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_active <= 1'b0;
            tx_active <= 1'b0;
            rx_flush  <= 1'b0;
            tx_flush  <= 1'b0;
        end else begin
            rx_active <= rx_act && !receive_soft_reset;
            tx_active <= tx_act && !transmit_soft_reset;
            rx_flush  <= rx_clr;
            tx_flush  <= tx_clr;
        end
    end
endmodule

// ### pkg/ubg_pkg.sv
// constants and types for the baud generator and rx/tx enable control
// assumes one 100 MHz clock and a synchronous active-high reset
package ubg_pkg;
    // ----------------------------------------------------------------
    // clock and divider sizes
    // ----------------------------------------------------------------
    localparam int         CD_W          = 16;
    localparam int         FP_W          = 3;
    localparam int         ETU_W         = 11;
    localparam int         SMP_W         = 5;
    localparam logic [2:0] MCK_DIV_LAST  = 3'h7;
    localparam logic [ETU_W-1:0] ETU_RESET = 11'h174;
    localparam logic [CD_W-1:0]  CD_OFF    = 16'h0000;
    localparam logic [CD_W-1:0]  CD_BYPASS = 16'h0001;
    localparam logic [FP_W-1:0]  FP_NONE   = 3'h0;
    localparam logic [SMP_W-1:0] OVER16_LAST = 5'h0f;
    localparam logic [SMP_W-1:0] OVER8_LAST  = 5'h07;
    localparam logic [SMP_W-1:0] SMP_ZERO    = 5'h00;
    // one less than the least high or low time of the master clock, in cycles
    localparam logic [2:0] SYNC_HALF_MIN = 3'h1;
    localparam logic [2:0] SPI_HALF_MIN  = 3'h2;

    // ----------------------------------------------------------------
    // mode fields
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        UBG_SRC_MCK  = 2'h0,
        UBG_SRC_DIV  = 2'h1,
        UBG_SRC_RSVD = 2'h2,
        UBG_SRC_EXT  = 2'h3
    } ubg_src_e;

    typedef enum logic [1:0] {
        UBG_MODE_ASYNC = 2'h0,
        UBG_MODE_SYNC  = 2'h1,
        UBG_MODE_SPI   = 2'h2,
        UBG_MODE_CARD  = 2'h3
    } ubg_mode_e;

    typedef enum logic [2:0] {
        UBG_PATH_IDLE  = 3'b001,
        UBG_PATH_RUN   = 3'b010,
        UBG_PATH_DRAIN = 3'b100
    } ubg_path_e;
endpackage
